// [design/fpep_flash_ctrl.sv]
// Flash program/erase sequencer with 1K-granule write protection and read-protection limits
// Assumes APB master on ref_clk, synchronous rst, protection state and request source as inputs
// Operation
// - Main memory is 64-byte pages from base
// - Option bytes sit in their own window
// - Write protection works on 1K granules
// - Factory configuration region is never reachable
// - Standard program writes one halfword
// - Standard erase uses 1K in main memory, chip erase wipes all of main memory
// - Fast page operations need the unlock sequence
// - Chip erase also allowed in fast method
// - Read protection locks pages 0 to 31, and page 32 against all but a 1K erase addressed to pages 33 to 47
// - Without read protection mask controls all pages
// - Protected untrusted requests allow only chip erase in main memory
// - Option bytes stay writable under read protection
// - Lifting read protection erases main memory first
`timescale 1ns/1ps
module fpep_flash_ctrl import fpep_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rdp_active,
   input wire logic untrusted_src,
   input wire logic rc_osc_ready,
   output logic busy,
   output fpep_cmd_type mem_cmd
);
   // Bus answer registers
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   // Software registers
   logic [31:0] addr_q, addr_d, data_q, data_d, wpr_q, wpr_d;
   logic [31:0] buf_q [16];
   logic [31:0] buf_d [16];
   logic fast_q, fast_d, key1_q, key1_d;
   fpep_op_type op_q, op_d;
   // Status flags
   logic eop_q, eop_d, wperr_q, wperr_d, rej_q, rej_d, busy_q, busy_d;
   // Sequencer state
   fpep_state_type state_q, state_d;
   logic [12:0] cnt_q, cnt_d;
   logic [3:0] idx_q, idx_d;
   fpep_cmd_type cmd_q, cmd_d;
   // Decode terms
   logic setup, wr_acc, start, in_main, in_opt, low_page, wpr_ok, main_err;
   logic is_fast, mode_bad, prot_err, release_rdp, accept;
   logic set_eop, set_wperr, set_rej;
   logic [14:0] off;
   logic [31:0] rd_word;
   fpep_op_type op_new;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign busy = busy_q;
   assign mem_cmd = cmd_q;

   // Bus phases and checks of a new request against the map and protection
   always_comb begin
      setup = psel && !penable;
      wr_acc = psel && penable && pready_q && pwrite && !pslverr_q;
      start = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_START];
      op_new = fpep_op_type'(pwdata[2:0]);
      off = addr_q[14:0];
      in_main = (addr_q >= MAIN_BASE) && (addr_q <= MAIN_LAST);
      in_opt = (addr_q >= OPT_BASE) && (addr_q <= OPT_LAST);
      low_page = off < RDP_LOW_END;
      // Mask bit per 16-page granule
      wpr_ok = wpr_q[off[14:GRAN_SH]];
      // Read protection forces low pages and untrusted sources out
      main_err = !wpr_ok || (rdp_active && (low_page || untrusted_src));
      is_fast = (op_new == OP_FPROG_PAGE) || (op_new == OP_FERASE_PAGE) || (op_new == OP_FERASE_1K);
      // Fast ops need the unlock; no op without the oscillator
      mode_bad = !rc_osc_ready || (is_fast && !fast_q);
      case (op_new)
         // Chip erase passes under any protection
         OP_ERASE_CHIP: prot_err = 1'b0;
         // Standard ops reach main or option bytes only
         OP_PROG_HALF, OP_ERASE_1K: prot_err = in_opt ? 1'b0 : (!in_main || main_err);
         // Fast ops reach main memory only
         OP_FPROG_PAGE, OP_FERASE_PAGE, OP_FERASE_1K: prot_err = !in_main || main_err;
         default: prot_err = 1'b1;
      endcase
      // Writing the release value into the protection option byte
      release_rdp = (op_new == OP_PROG_HALF) && in_opt && (addr_q[5:0] == 6'h00) &&
                    (data_q[7:0] == RDP_RELEASE) && rdp_active;
      accept = start && !busy_q && !mode_bad && !prot_err;
   end

   // Read mux and unmapped detection, evaluated in the setup cycle
   always_comb begin
      rd_word = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (paddr[1:0] != 2'h0) begin
         pslverr_d = 1'b1; // Misaligned
      end else if (paddr == REG_CTRL) begin
         rd_word = {29'h0000_0000, op_q};
      end else if (paddr == REG_STAT) begin
         rd_word = {24'h00_0000, fast_q, rej_q, eop_q, wperr_q, 3'h0, busy_q};
      end else if (paddr == REG_ADDR) begin
         rd_word = addr_q;
      end else if (paddr == REG_DATA) begin
         rd_word = data_q;
      end else if (paddr == REG_WPR) begin
         rd_word = wpr_q;
      end else if (paddr == REG_MODEKEY) begin
         rd_word = 32'h0000_0000; // Keys read as zero
      end else if (paddr[7:6] == REG_BUF_SEL) begin
         rd_word = buf_q[paddr[5:2]];
      end else begin
         pslverr_d = 1'b1; // Unmapped
      end
      pready_d = setup; // No wait state, answer in the first access cycle
      prdata_d = setup ? rd_word : prdata_q;
   end

   // Register writes, sequencer and status flags
   always_comb begin
      addr_d = addr_q;
      data_d = data_q;
      wpr_d = wpr_q;
      buf_d = buf_q;
      fast_d = fast_q;
      key1_d = key1_q;
      op_d = op_q;
      state_d = state_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      busy_d = busy_q;
      cmd_d = cmd_q;
      cmd_d.strobe = 1'b0;
      set_eop = 1'b0;
      set_wperr = 1'b0;
      set_rej = 1'b0;
      // Software writes; operands hold still while busy
      if (wr_acc) begin
         if (paddr == REG_ADDR && !busy_q) begin
            addr_d = pwdata;
         end else if (paddr == REG_DATA && !busy_q) begin
            data_d = pwdata;
         end else if (paddr == REG_WPR) begin
            wpr_d = pwdata;
         end else if (paddr == REG_MODEKEY) begin
            // Two keys in order open the fast method
            if (!key1_q) begin
               key1_d = (pwdata == FAST_KEY1);
            end else begin
               key1_d = 1'b0;
               fast_d = fast_q || (pwdata == FAST_KEY2);
            end
         end else if (paddr == REG_CTRL && pwdata[CTRL_RELOCK]) begin
            fast_d = 1'b0;
            key1_d = 1'b0;
         end else if (paddr[7:6] == REG_BUF_SEL && !busy_q) begin
            buf_d[paddr[5:2]] = pwdata;
         end
      end
      // Overlapping start is refused
      if (start && busy_q) begin
         set_rej = 1'b1;
      end
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               op_d = op_new;
               if (mode_bad) begin
                  set_rej = 1'b1;
               end else if (prot_err) begin
                  set_wperr = 1'b1;
               end else begin
                  busy_d = 1'b1;
                  cmd_d.strobe = 1'b1;
                  cmd_d.data = 32'h0000_0000;
                  cnt_d = TERASE_CYC - 13'h0001;
                  state_d = ST_WAIT;
                  if (release_rdp) begin
                     // Wipe main memory before the option byte changes
                     cmd_d.op = MOP_ERASEALL;
                     cmd_d.addr = MAIN_BASE;
                     state_d = ST_ERALL;
                  end else begin
                     case (op_new)
                        OP_PROG_HALF: begin
                           // One halfword per request
                           cmd_d.op = MOP_PROG16;
                           cmd_d.addr = {addr_q[31:1], 1'b0};
                           cmd_d.data = {16'h0000, data_q[15:0]};
                           cnt_d = TPROG_CYC - 13'h0001;
                        end
                        OP_ERASE_1K, OP_FERASE_1K: begin
                           // Option window erases as one block
                           cmd_d.op = in_opt ? MOP_ERASE64 : MOP_ERASE1K;
                           cmd_d.addr = in_opt ? OPT_BASE : {addr_q[31:GRAN_SH], 10'h000};
                        end
                        OP_FERASE_PAGE: begin
                           cmd_d.op = MOP_ERASE64;
                           cmd_d.addr = {addr_q[31:PAGE_SH], 6'h00};
                        end
                        OP_FPROG_PAGE: begin
                           // First word now, fifteen more follow
                           cmd_d.op = MOP_PROG32;
                           cmd_d.addr = {addr_q[31:PAGE_SH], 6'h00};
                           cmd_d.data = buf_q[0];
                           idx_d = 4'h1;
                           state_d = ST_PROG;
                        end
                        default: begin
                           // Whole-chip erase
                           cmd_d.op = MOP_ERASEALL;
                           cmd_d.addr = MAIN_BASE;
                        end
                     endcase
                  end
               end
            end
         end
         ST_ERALL: begin
            // After the wipe, program the option byte
            if (cnt_q == 13'h0000) begin
               cmd_d.strobe = 1'b1;
               cmd_d.op = MOP_PROG16;
               cmd_d.addr = OPT_BASE;
               cmd_d.data = {16'h0000, data_q[15:0]};
               cnt_d = TPROG_CYC - 13'h0001;
               state_d = ST_WAIT;
            end else begin
               cnt_d = cnt_q - 13'h0001;
            end
         end
         ST_PROG: begin
            // Stream the page buffer one word per cycle
            cmd_d.strobe = 1'b1;
            cmd_d.addr = {cmd_q.addr[31:PAGE_SH], idx_q, 2'h0};
            cmd_d.data = buf_q[idx_q];
            idx_d = idx_q + 4'h1;
            if (idx_q == 4'hF) begin
               cnt_d = TPROG_CYC - 13'h0001;
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Hold busy for the array time
            if (cnt_q == 13'h0000) begin
               busy_d = 1'b0;
               set_eop = 1'b1;
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 13'h0001;
            end
         end
         default: begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
         end
      endcase
      // Write one clears, a same-cycle set wins
      eop_d = (eop_q && !(wr_acc && paddr == REG_STAT && pwdata[STAT_EOP])) || set_eop;
      wperr_d = (wperr_q && !(wr_acc && paddr == REG_STAT && pwdata[STAT_WPERR])) || set_wperr;
      rej_d = (rej_q && !(wr_acc && paddr == REG_STAT && pwdata[STAT_REJ])) || set_rej;
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         data_q <= 32'h0000_0000;
         wpr_q <= WPR_RST;
         for (int i = 0; i < 16; i++) begin
            buf_q[i] <= 32'h0000_0000;
         end
         fast_q <= 1'b0;
         key1_q <= 1'b0;
         op_q <= OP_NONE;
         eop_q <= 1'b0;
         wperr_q <= 1'b0;
         rej_q <= 1'b0;
         busy_q <= 1'b0;
         state_q <= ST_IDLE;
         cnt_q <= 13'h0000;
         idx_q <= 4'h0;
         cmd_q <= '0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= setup ? pslverr_d : 1'b0;
         addr_q <= addr_d;
         data_q <= data_d;
         wpr_q <= wpr_d;
         buf_q <= buf_d;
         fast_q <= fast_d;
         key1_q <= key1_d;
         op_q <= op_d;
         eop_q <= eop_d;
         wperr_q <= wperr_d;
         rej_q <= rej_d;
         busy_q <= busy_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         idx_q <= idx_d;
         cmd_q <= cmd_d;
      end
   end

   // Checks on the sequencer
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_burst8;
      mem_cmd.strobe [*8];
   endsequence
   sequence s_wipe_start;
      mem_cmd.strobe && mem_cmd.op == MOP_ERASEALL;
   endsequence

   property p_rej_busy;
      start && busy_q |=> rej_q && busy_q;
   endproperty
   a_rej_busy: assert property (p_rej_busy) else $error("start while busy not rejected");

   property p_prot_err;
      start && !busy_q && !mode_bad && prot_err |=> wperr_q && !mem_cmd.strobe && !busy_q;
   endproperty
   a_prot_err: assert property (p_prot_err) else $error("protected target not refused");

   property p_half;
      mem_cmd.strobe && mem_cmd.op == MOP_PROG16 |-> mem_cmd.data[31:16] == 16'h0000 && !mem_cmd.addr[0];
   endproperty
   a_half: assert property (p_half) else $error("halfword program malformed");

   property p_page;
      accept && op_new == OP_FPROG_PAGE && !release_rdp |=> s_burst8 ##1 s_burst8 ##1 !mem_cmd.strobe;
   endproperty
   a_page: assert property (p_page) else $error("page program not sixteen words");

   property p_fast_lock;
      start && !busy_q && is_fast && !fast_q |=> rej_q && !mem_cmd.strobe && !busy_q;
   endproperty
   a_fast_lock: assert property (p_fast_lock) else $error("fast op accepted while locked");

   property p_release;
      accept && release_rdp |=> s_wipe_start ##1 (busy_q && !mem_cmd.strobe) [*8];
   endproperty
   a_release: assert property (p_release) else $error("release did not wipe first");

   property p_chip_rdp;
      start && !busy_q && rc_osc_ready && op_new == OP_ERASE_CHIP && rdp_active |=> s_wipe_start and busy_q;
   endproperty
   a_chip_rdp: assert property (p_chip_rdp) else $error("chip erase refused");

   property p_low_pages;
      mem_cmd.strobe && rdp_active && mem_cmd.op != MOP_ERASEALL && mem_cmd.addr >= MAIN_BASE &&
         mem_cmd.addr <= MAIN_LAST |-> mem_cmd.addr[14:0] >= RDP_LOW_END;
   endproperty
   a_low_pages: assert property (p_low_pages) else $error("low page touched under protection");

   property p_eop;
      busy_q && state_q == ST_WAIT && cnt_q == 13'h0000 |=> !busy_q && eop_q;
   endproperty
   a_eop: assert property (p_eop) else $error("end of operation not flagged");
endmodule

// [inc/fpep_pkg.sv]
// Package for the flash program, erase and protection sequencer
// Assumes one 100 MHz clock, an APB register port and a flash macro that takes strobed commands
package fpep_pkg;
   // Clock period and operation times in their own unit
   localparam int CLK_NS = 10;
   localparam int TPROG_NS = 20000; // Program time of one unit
   localparam int TERASE_NS = 40000; // Erase time of any unit
   localparam logic [12:0] TPROG_CYC = 13'((TPROG_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [12:0] TERASE_CYC = 13'((TERASE_NS + CLK_NS - 1) / CLK_NS);
   // Memory map of the array
   localparam logic [31:0] MAIN_BASE = 32'h0800_0000;
   localparam logic [31:0] MAIN_LAST = 32'h0800_3FFF;
   localparam logic [31:0] OPT_BASE = 32'h1FFF_F800;
   localparam logic [31:0] OPT_LAST = 32'h1FFF_F83F;
   localparam int PAGE_SH = 6; // 64-byte page
   localparam int GRAN_SH = 10; // 1K granule of 16 pages
   localparam logic [14:0] RDP_LOW_END = 15'h0840; // First byte after page 32
   localparam logic [7:0] RDP_RELEASE = 8'hA5; // Option value that lifts read protection
   // Keys that open the fast method
   localparam logic [31:0] FAST_KEY1 = 32'h4567_0123;
   localparam logic [31:0] FAST_KEY2 = 32'hCDEF_89AB;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_WPR = 8'h10;
   localparam logic [7:0] REG_MODEKEY = 8'h14;
   localparam logic [1:0] REG_BUF_SEL = 2'h1; // Page buffer at 0x40..0x7C
   // Reset values
   localparam logic [31:0] WPR_RST = 32'hFFFF_FFFF;
   // Control and status field positions
   localparam int CTRL_START = 4;
   localparam int CTRL_RELOCK = 5;
   localparam int STAT_WPERR = 4;
   localparam int STAT_EOP = 5;
   localparam int STAT_REJ = 6;
   // Software operation codes
   typedef enum logic [2:0] {
      OP_NONE = 3'h0, OP_PROG_HALF = 3'h1, OP_ERASE_1K = 3'h2, OP_ERASE_CHIP = 3'h3,
      OP_FPROG_PAGE = 3'h4, OP_FERASE_PAGE = 3'h5, OP_FERASE_1K = 3'h6
   } fpep_op_type;
   // Commands to the flash macro
   typedef enum logic [2:0] {
      MOP_NONE = 3'h0, MOP_PROG16 = 3'h1, MOP_PROG32 = 3'h2, MOP_ERASE64 = 3'h3,
      MOP_ERASE1K = 3'h4, MOP_ERASEALL = 3'h5
   } fpep_mop_type;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_ERALL = 4'b0010, ST_PROG = 4'b0100, ST_WAIT = 4'b1000
   } fpep_state_type;
   // One command to the flash macro
   typedef struct packed {
      logic strobe;
      fpep_mop_type op;
      logic [31:0] addr;
      logic [31:0] data;
   } fpep_cmd_type;
endpackage

// [dv/fpep_req_model.sv]
// Requester model: an APB master standing for the core, boot code or debug port
// Assumes the controller answers on ref_clk and raises pready for one cycle
`timescale 1ns/1ps
module fpep_req_model (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // One transfer, held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
         output logic [31:0] rdata, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Wait for the answer however long; only the bench timeout ends a hang
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data is inverted so stale data never looks valid
      pwdata <= ~wdata;
   endtask
endmodule

// [dv/tb.sv]
// Testbench for the flash program, erase and protection sequencer
// Assumes the requester model for APB and a monitor of the flash macro commands
`timescale 1ns/1ps
module tb;
   import fpep_pkg::*;
   // One table row: levels, request, mask and what should follow
   typedef struct packed {
      logic rdp; logic unt; logic [2:0] op; logic [31:0] addr; logic [31:0] wpr;
      logic [31:0] stat; logic [4:0] nstr; logic [2:0] mop;
   } fpep_row_type;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, busy;
   logic rdp_active, untrusted_src, rc_osc_ready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v, last_addr, last_data;
   logic err_v;
   logic [2:0] last_op, first_op;
   fpep_cmd_type mem_cmd;
   int n_mismatch = 0, compares = 0, cycles = 0, n_str = 0;
   // Ordinary cases; stat 0x20 done, 0x10 protection error, 0x40 refused
   fpep_row_type rows [14] = '{
      '{0, 0, 3'h1, 32'h0800_1000, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h1},
      '{0, 0, 3'h2, 32'h0800_0400, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h4},
      '{0, 0, 3'h3, 32'h0800_0000, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h5},
      '{0, 0, 3'h1, 32'h0800_1000, 32'hFFFF_FFEF, 32'h10, 5'd0, 3'h0},
      '{0, 0, 3'h1, 32'h0800_0FFE, 32'hFFFF_FFEF, 32'h20, 5'd1, 3'h1},
      '{1, 0, 3'h1, 32'h0800_083E, 32'hFFFF_FFFF, 32'h10, 5'd0, 3'h0},
      '{1, 0, 3'h1, 32'h0800_0840, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h1},
      '{1, 1, 3'h1, 32'h0800_2000, 32'hFFFF_FFFF, 32'h10, 5'd0, 3'h0},
      '{1, 1, 3'h3, 32'h0800_0000, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h5},
      '{1, 1, 3'h1, 32'h1FFF_F802, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h1},
      '{0, 0, 3'h1, 32'h0800_0000, 32'hFFFF_FFFF, 32'h20, 5'd1, 3'h1},
      '{0, 0, 3'h1, 32'h1FFF_F7E0, 32'hFFFF_FFFF, 32'h10, 5'd0, 3'h0},
      '{0, 0, 3'h1, 32'h0800_4000, 32'hFFFF_FFFF, 32'h10, 5'd0, 3'h0},
      '{0, 0, 3'h5, 32'h0800_0040, 32'hFFFF_FFFF, 32'h40, 5'd0, 3'h0}
   };
   // Design and requester
   fpep_flash_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rdp_active(rdp_active), .untrusted_src(untrusted_src), .rc_osc_ready(rc_osc_ready),
      .busy(busy), .mem_cmd(mem_cmd));
   fpep_req_model i_req (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Records macro commands and cuts a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (mem_cmd.strobe === 1'b1) begin
         if (n_str == 0) first_op = mem_cmd.op;
         n_str++;
         last_op = mem_cmd.op;
         last_addr = mem_cmd.addr;
         last_data = mem_cmd.data;
      end
      if (cycles == 80000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // Verdict and end of run
   task automatic wrap_up();
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Value comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One register access
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_req.xfer(w, a, d, rd_v, err_v);
   endtask
   // Loads address and data, then starts an operation
   task automatic issue(input logic [2:0] op, input logic [31:0] a, input logic [31:0] d);
      n_str = 0;
      bus(1'b1, REG_ADDR, a);
      bus(1'b1, REG_DATA, d);
      bus(1'b1, REG_CTRL, {27'h0, 1'b1, 1'b0, op});
   endtask
   // Waits out busy under a bound
   task automatic settle();
      int n = 0;
      repeat (2) @(posedge ref_clk);
      while (busy === 1'b1 && n < 7000) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   // Status flags, command count, last command; then flags cleared
   task automatic expect_op(input logic [31:0] st, input int ns, input logic [2:0] mop, input logic [31:0] a);
      bus(1'b0, REG_STAT, 32'h0);
      chk("stat", st, rd_v & 32'h70);
      chk("strobes", 32'(ns), 32'(n_str));
      if (ns > 0) chk("op", 32'(mop), 32'(last_op));
      if (ns > 0 && mop != 3'h5) chk("addr", a, last_addr);
      bus(1'b1, REG_STAT, 32'h70);
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      rdp_active = 1'b0;
      untrusted_src = 1'b0;
      rc_osc_ready = 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk("busy", 32'h0, 32'(busy));
      bus(1'b0, REG_WPR, 32'h0);
      chk("wpr", WPR_RST, rd_v);
      bus(1'b0, 8'h20, 32'h0);
      chk("slverr", 32'h1, 32'(err_v));
      foreach (rows[i]) begin
         @(posedge ref_clk);
         rdp_active <= rows[i].rdp;
         untrusted_src <= rows[i].unt;
         bus(1'b1, REG_WPR, rows[i].wpr);
         issue(rows[i].op, rows[i].addr, 32'hABCD_1234);
         settle();
         if (rows[i].mop == 3'h1) chk("data", 32'h0000_1234, last_data);
         expect_op(rows[i].stat, rows[i].nstr, rows[i].mop, rows[i].addr);
      end
      // Unlock the fast method, then every fast operation
      @(posedge ref_clk);
      rdp_active <= 1'b0;
      untrusted_src <= 1'b0;
      bus(1'b1, REG_MODEKEY, FAST_KEY1);
      bus(1'b1, REG_MODEKEY, FAST_KEY2);
      bus(1'b0, REG_STAT, 32'h0);
      chk("unlocked", 32'h80, rd_v & 32'h80);
      issue(3'h5, 32'h0800_0040, 32'h0);
      settle();
      expect_op(32'h20, 1, 3'h3, 32'h0800_0040);
      issue(3'h6, 32'h0800_0800, 32'h0);
      settle();
      expect_op(32'h20, 1, 3'h4, 32'h0800_0800);
      for (int i = 0; i < 16; i++) bus(1'b1, 8'(8'h40 + 4 * i), 32'(i));
      issue(3'h4, 32'h0800_0080, 32'h0);
      settle();
      expect_op(32'h20, 16, 3'h2, 32'h0800_00BC);
      chk("data", 32'h0000_000F, last_data);
      issue(3'h3, 32'h0800_0000, 32'h0);
      settle();
      expect_op(32'h20, 1, 3'h5, 32'h0);
      // Oscillator stopped: fast operation must be refused
      @(posedge ref_clk);
      rc_osc_ready <= 1'b0;
      issue(3'h5, 32'h0800_0040, 32'h0);
      settle();
      expect_op(32'h40, 0, 3'h0, 32'h0);
      @(posedge ref_clk);
      rc_osc_ready <= 1'b1;
      // Second start while busy is refused, first one completes
      issue(3'h1, 32'h0800_3000, 32'h0);
      bus(1'b1, REG_CTRL, 32'h0000_0011);
      chk("busy", 32'h1, 32'(busy));
      settle();
      expect_op(32'h60, 1, 3'h1, 32'h0800_3000);
      // Lifting read protection erases main memory first
      @(posedge ref_clk);
      rdp_active <= 1'b1;
      issue(3'h1, OPT_BASE, {24'h0, RDP_RELEASE});
      settle();
      chk("first", 32'h5, 32'(first_op));
      expect_op(32'h20, 2, 3'h1, OPT_BASE);
      chk("data", 32'h0000_00A5, last_data);
      // Reset in mid operation drops busy, flags and the fast unlock
      @(posedge ref_clk);
      rdp_active <= 1'b0;
      issue(3'h2, 32'h0800_0400, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk("busy", 32'h0, 32'(busy));
      bus(1'b0, REG_STAT, 32'h0);
      chk("stat", 32'h0, rd_v);
      wrap_up();
   end
endmodule
